// file: core/wdtoc_defs.svh
// Constants for the watchdog option configuration block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef WDTOC_DEFS_SVH
`define WDTOC_DEFS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define WDTOC_ADDR_W          8
`define WDTOC_ADDR_RESTART    8'h00
`define WDTOC_ADDR_OSC_MODE   8'h04
`define WDTOC_ADDR_RESET_FLAG 8'h08
`define WDTOC_ADDR_STATUS     8'h0c
`define WDTOC_ADDR_OPTION     8'h80

// ****************************************************************
// Option byte fields
// ****************************************************************
`define WDTOC_OPT_W           8
`define WDTOC_OPT_PAD_BIT     7
`define WDTOC_WIN_HI          6
`define WDTOC_WIN_LO          5
`define WDTOC_START_BIT       4
`define WDTOC_OVF_HI          3
`define WDTOC_OVF_LO          1
`define WDTOC_LOCK_BIT        0

// ****************************************************************
// Other register fields and codes
// ****************************************************************
`define WDTOC_OSC_STOP_BIT    1
`define WDTOC_CAUSE_BIT       4
`define WDTOC_RESTART_CODE    8'hac
`define WDTOC_ST_WIN_BIT      17
`define WDTOC_ST_RUN_BIT      18
`define WDTOC_ST_MISM_BIT     19
`define WDTOC_RESP_OKAY       2'h0
`define WDTOC_RESP_SLVERR     2'h2

// ****************************************************************
// Counter and timing
// ****************************************************************
`define WDTOC_CNT_W           17
`define WDTOC_PER_W           18
`define WDTOC_OVF_BASE        10
`define WDTOC_WIN_W           2
`define WDTOC_SEL_W           3
`define WDTOC_SYNC_W          18
`define WDTOC_LOAD_W          2
`define WDTOC_LOAD_DLY        2'h2

`endif

// file: core/wdtoc_pkg.sv
// Types shared by the watchdog option configuration block.
// Assumes wdtoc_defs.svh is on the include path.
`include "wdtoc_defs.svh"

package wdtoc_pkg;

  typedef logic [`WDTOC_OPT_W-1:0] wdtoc_opt_t;
  typedef logic [`WDTOC_CNT_W-1:0] wdtoc_cnt_t;

  typedef enum logic [1:0] {
    WDTOC_WR_ADDR = 2'b00,
    WDTOC_WR_EXEC = 2'b01,
    WDTOC_WR_RESP = 2'b10
  } wdtoc_wr_state_t;

  typedef enum logic [0:0] {
    WDTOC_RD_IDLE = 1'b0,
    WDTOC_RD_DATA = 1'b1
  } wdtoc_rd_state_t;

endpackage

// file: core/wdtoc_sync.sv
// Two-stage synchroniser for pin inputs of the watchdog block.
// Assumes inputs are asynchronous to clk_i; only stage two is read outside.
`timescale 1ns/1ps
`include "wdtoc_defs.svh"

module wdtoc_sync
(
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  input  wire logic [`WDTOC_SYNC_W-1:0] async_i,
  output logic      [`WDTOC_SYNC_W-1:0] sync_o
);

  logic [`WDTOC_SYNC_W-1:0] stage1;

  // ****************************************************************
  // Per-bit double flop
  // ****************************************************************
  genvar b;
  generate
    for (b = 0; b < `WDTOC_SYNC_W; b = b + 1)
    begin : g_bit
      always_ff @(posedge clk_i)
      begin
        if (!nrst_i)
        begin
          stage1[b] <= 1'b0;
          sync_o[b] <= 1'b0;
        end
        else
        begin
          stage1[b] <= async_i[b];
          sync_o[b] <= stage1[b];
        end
      end
    end
  endgenerate

endmodule

// file: core/wdtoc_counter.sv
// Watchdog period counter with window comparison.
// Assumes one tick per low-speed oscillator cycle, on clk_i.
`timescale 1ns/1ps
`include "wdtoc_defs.svh"

module wdtoc_counter
  import wdtoc_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    tick_i,
  input  wire logic                    clear_i,
  input  wire logic [`WDTOC_SEL_W-1:0] ovf_sel_i,
  input  wire logic [`WDTOC_WIN_W-1:0] win_sel_i,
  output wdtoc_pkg::wdtoc_cnt_t        count_o,
  output logic                         window_open_o,
  output logic                         overflow_o
);

  logic [`WDTOC_PER_W-1:0] period;
  logic [`WDTOC_PER_W-1:0] quarter;
  logic [`WDTOC_PER_W-1:0] open_thr;
  logic [`WDTOC_PER_W-1:0] count_w;

  // ****************************************************************
  // Period and window threshold
  // ****************************************************************
  assign period  = `WDTOC_PER_W'(1) << (`WDTOC_OVF_BASE + 32'(ovf_sel_i));
  assign quarter = period >> 2;
  // Open part sits at the end of the period
  assign open_thr = (win_sel_i == 2'h0) ? (quarter + (quarter << 1)) :
                    (win_sel_i == 2'h1) ? (quarter << 1) :
                    (win_sel_i == 2'h2) ? quarter : `WDTOC_PER_W'(0);
  assign count_w       = {1'b0, count_o};
  assign window_open_o = (count_w >= open_thr);
  assign overflow_o    = tick_i && (count_w == (period - `WDTOC_PER_W'(1)));

  // ****************************************************************
  // Count register
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      count_o <= '0;
    else if (clear_i || overflow_o)
      count_o <= '0;
    else if (tick_i)
      count_o <= count_o + `WDTOC_CNT_W'(1);
  end

endmodule

// file: core/wdtoc_top.sv
// Watchdog option configuration: option byte latch, watchdog, oscillator
// control and an AXI4-Lite register slave.
// Assumes option bytes and the oscillator clock are pins; halt, stop and
// illegal-access strobes come from logic on clk_i.
//
// Functional notes
// - Window field picks open fraction 25, 50, 75 or 100 percent.
// - Start bit 0 keeps counter stopped and illegal-access detection off.
// - Start bit 1 starts counting at reset and enables illegal-access detection.
// - Overflow field n gives period of 2^(10+n) oscillator cycles.
// - Lock bit 0 lets the stop bit halt the low-speed oscillator.
// - Lock bit 1 keeps oscillator running; stop bit writes still land in the register but have no effect.
// - Counter keeps running during flash self-programming.
// - Lock bit 0 withholds watchdog ticks in halt and stop.
// - Eight-bit timer tick continues in halt and stop.
// - Counter overflow raises internal reset.
// - Non-restart-code write to restart register raises internal reset.
// - Restart write while window closed raises internal reset.
// - Watchdog reset sets reset-cause flag.
`timescale 1ns/1ps
`include "wdtoc_defs.svh"

module wdtoc_top
  import wdtoc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wdtoc_pkg::wdtoc_opt_t option_main_i,
  input  wdtoc_pkg::wdtoc_opt_t option_alt_i,
  input  wire logic        boot_swap_i,
  input  wire logic        lowspeed_osc_i,
  input  wire logic        halt_i,
  input  wire logic        stop_i,
  input  wire logic        illegal_access_i,
  output logic             wdt_reset_o,
  output logic             lowspeed_osc_en_o,
  output logic             timer8_tick_o,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  import wdtoc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [`WDTOC_SYNC_W-1:0] sync_q;
  wdtoc_opt_t               main_s;
  wdtoc_opt_t               alt_s;
  logic                     swap_s;
  logic                     osc_s;
  logic                     osc_prev;
  logic [`WDTOC_LOAD_W-1:0] load_cnt;
  logic                     cfg_loaded;
  wdtoc_opt_t               cfg_byte;
  logic                     cfg_mismatch;
  logic                     osc_stop;
  logic                     reset_cause_flag;
  wdtoc_wr_state_t          wr_state;
  wdtoc_rd_state_t          rd_state;
  logic                     aw_got;
  logic                     w_got;
  logic [`WDTOC_ADDR_W-1:0] wr_addr;
  logic [31:0]              wr_data;
  logic [3:0]               wr_strb;
  wdtoc_cnt_t               count;
  logic                     window_open;
  logic                     overflow;

  wire wdtoc_opt_t               sel_byte;
  wire logic [`WDTOC_WIN_W-1:0]  window_sel;
  wire logic [`WDTOC_SEL_W-1:0]  overflow_sel;
  wire logic                     start_at_reset_bit;
  wire logic                     osc_lock_bit;
  wire logic                     wdt_active;
  wire logic                     osc_edge;
  wire logic                     sleep_gate;
  wire logic                     wdt_tick;
  wire logic                     wr_fire;
  wire logic                     wr_low_byte;
  wire logic                     restart_wr;
  wire logic                     restart_bad;
  wire logic                     restart_ok;
  wire logic                     illegal_hit;
  wire logic                     wdt_trip;
  wire logic                     osc_mode_wr;
  wire logic                     cause_clear;
  wire logic                     wr_mapped;
  wire logic                     rd_mapped;
  wire logic [31:0]              rd_mux;
  wire logic [31:0]              status_word;
  wire logic                     next_osc_en;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Option bytes are straps; synchronising them costs two cycles only
  wdtoc_sync u_sync
  (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .async_i ({lowspeed_osc_i, boot_swap_i, option_alt_i, option_main_i}),
    .sync_o  (sync_q)
  );

  assign main_s = sync_q[`WDTOC_OPT_W-1:0];
  assign alt_s  = sync_q[2*`WDTOC_OPT_W-1:`WDTOC_OPT_W];
  assign swap_s = sync_q[2*`WDTOC_OPT_W];
  assign osc_s  = sync_q[2*`WDTOC_OPT_W+1];

  // ****************************************************************
  // Option byte latch
  // ****************************************************************
  // Wait for synchroniser to fill before sampling the straps
  assign sel_byte = swap_s ? alt_s : main_s;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      load_cnt     <= '0;
      cfg_loaded   <= 1'b0;
      cfg_byte     <= '0;
      cfg_mismatch <= 1'b0;
    end
    else if (!cfg_loaded)
    begin
      load_cnt <= load_cnt + `WDTOC_LOAD_W'(1);
      if (load_cnt == `WDTOC_LOAD_DLY)
      begin
        cfg_byte     <= sel_byte;
        cfg_loaded   <= 1'b1;
        cfg_mismatch <= (main_s != alt_s);
      end
    end
  end

  assign window_sel         = cfg_byte[`WDTOC_WIN_HI:`WDTOC_WIN_LO];
  assign start_at_reset_bit = cfg_byte[`WDTOC_START_BIT];
  assign overflow_sel       = cfg_byte[`WDTOC_OVF_HI:`WDTOC_OVF_LO];
  assign osc_lock_bit       = cfg_byte[`WDTOC_LOCK_BIT];

  // ****************************************************************
  // Oscillator and tick gating
  // ****************************************************************
  assign next_osc_en = osc_lock_bit || !osc_stop;
  assign osc_edge    = osc_s && !osc_prev && lowspeed_osc_en_o;
  assign sleep_gate  = !osc_lock_bit && (halt_i || stop_i);
  assign wdt_active  = cfg_loaded && start_at_reset_bit;
  // No flash-busy term: counting goes on during self-programming
  assign wdt_tick    = wdt_active && osc_edge && !sleep_gate;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      osc_prev          <= 1'b0;
      lowspeed_osc_en_o <= 1'b1;
      timer8_tick_o     <= 1'b0;
    end
    else
    begin
      osc_prev          <= osc_s;
      lowspeed_osc_en_o <= next_osc_en;
      timer8_tick_o     <= osc_edge;
    end
  end

  // ****************************************************************
  // Watchdog counter
  // ****************************************************************
  wdtoc_counter u_counter
  (
    .clk_i         (clk_i),
    .nrst_i        (nrst_i),
    .tick_i        (wdt_tick),
    .clear_i       (restart_ok || wdt_trip),
    .ovf_sel_i     (overflow_sel),
    .win_sel_i     (window_sel),
    .count_o       (count),
    .window_open_o (window_open),
    .overflow_o    (overflow)
  );

  // ****************************************************************
  // Restart and trip detection
  // ****************************************************************
  assign wr_fire     = (wr_state == WDTOC_WR_EXEC);
  assign wr_low_byte = wr_fire && wr_strb[0];
  assign restart_wr  = wr_low_byte && (wr_addr == `WDTOC_ADDR_RESTART) && wdt_active;
  assign restart_bad = wr_data[7:0] != `WDTOC_RESTART_CODE;
  assign restart_ok  = restart_wr && !restart_bad && window_open;
  assign illegal_hit = illegal_access_i && wdt_active;
  assign wdt_trip    = overflow
                    || (restart_wr && restart_bad)
                    || (restart_wr && !window_open)
                    || illegal_hit;

  assign osc_mode_wr = wr_low_byte && (wr_addr == `WDTOC_ADDR_OSC_MODE);
  assign cause_clear = wr_low_byte && (wr_addr == `WDTOC_ADDR_RESET_FLAG)
                    && !wr_data[`WDTOC_CAUSE_BIT];

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      wdt_reset_o      <= 1'b0;
      reset_cause_flag <= 1'b0;
      osc_stop         <= 1'b0;
    end
    else
    begin
      wdt_reset_o <= wdt_trip;
      // Set beats a clear arriving in the same cycle
      if (wdt_trip)
        reset_cause_flag <= 1'b1;
      else if (cause_clear)
        reset_cause_flag <= 1'b0;
      if (osc_mode_wr)
        osc_stop <= wr_data[`WDTOC_OSC_STOP_BIT];
    end
  end

  // ****************************************************************
  // Register decode
  // ****************************************************************
  assign status_word = {12'h000, cfg_mismatch, wdt_active, window_open, count};
  assign wr_mapped = (wr_addr == `WDTOC_ADDR_RESTART)
                  || (wr_addr == `WDTOC_ADDR_OSC_MODE)
                  || (wr_addr == `WDTOC_ADDR_RESET_FLAG);
  assign rd_mapped = wr_mapped_rd(s_axi_araddr);
  assign rd_mux =
    (s_axi_araddr == `WDTOC_ADDR_OSC_MODE)   ? 32'(osc_stop) << `WDTOC_OSC_STOP_BIT :
    (s_axi_araddr == `WDTOC_ADDR_RESET_FLAG) ? 32'(reset_cause_flag) << `WDTOC_CAUSE_BIT :
    (s_axi_araddr == `WDTOC_ADDR_STATUS)     ? status_word :
    (s_axi_araddr == `WDTOC_ADDR_OPTION)     ? 32'(cfg_byte) : 32'h0000_0000;

  function automatic logic wr_mapped_rd(input logic [`WDTOC_ADDR_W-1:0] a);
    wr_mapped_rd = (a == `WDTOC_ADDR_RESTART) || (a == `WDTOC_ADDR_OSC_MODE)
                || (a == `WDTOC_ADDR_RESET_FLAG) || (a == `WDTOC_ADDR_STATUS)
                || (a == `WDTOC_ADDR_OPTION);
  endfunction

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // Address and data are taken in either order; response follows both
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      wr_state      <= WDTOC_WR_ADDR;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      wr_addr       <= '0;
      wr_data       <= '0;
      wr_strb       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WDTOC_RESP_OKAY;
    end
    else
    begin
      case (wr_state)
        WDTOC_WR_ADDR:
        begin
          s_axi_awready <= !aw_got && !(s_axi_awvalid && s_axi_awready);
          s_axi_wready  <= !w_got && !(s_axi_wvalid && s_axi_wready);
          if (s_axi_awvalid && s_axi_awready)
          begin
            aw_got  <= 1'b1;
            wr_addr <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready)
          begin
            w_got   <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
          end
          if (aw_got && w_got)
          begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            wr_state      <= WDTOC_WR_EXEC;
          end
        end
        WDTOC_WR_EXEC:
        begin
          aw_got       <= 1'b0;
          w_got        <= 1'b0;
          s_axi_bvalid <= 1'b1;
          s_axi_bresp  <= wr_mapped ? `WDTOC_RESP_OKAY : `WDTOC_RESP_SLVERR;
          wr_state     <= WDTOC_WR_RESP;
        end
        WDTOC_WR_RESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            wr_state     <= WDTOC_WR_ADDR;
          end
        end
        default:
          wr_state <= WDTOC_WR_ADDR;
      endcase
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      rd_state      <= WDTOC_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `WDTOC_RESP_OKAY;
    end
    else
    begin
      case (rd_state)
        WDTOC_RD_IDLE:
        begin
          s_axi_arready <= 1'b1;
          if (s_axi_arvalid && s_axi_arready)
          begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_mapped ? `WDTOC_RESP_OKAY : `WDTOC_RESP_SLVERR;
            rd_state      <= WDTOC_RD_DATA;
          end
        end
        WDTOC_RD_DATA:
        begin
          if (s_axi_rready)
          begin
            s_axi_rvalid <= 1'b0;
            rd_state     <= WDTOC_RD_IDLE;
          end
        end
        default:
          rd_state <= WDTOC_RD_IDLE;
      endcase
    end
  end

endmodule

// file: tb/wdtoc_top_checker.sv
// Port checker for the watchdog option configuration top.
// Assumes straps are only changed while reset is held, except on purpose.
`timescale 1ns/1ps

module wdtoc_top_checker
  import wdtoc_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            nrst_i,
  input  wdtoc_pkg::wdtoc_opt_t option_main_i,
  input  wdtoc_pkg::wdtoc_opt_t option_alt_i,
  input  wire logic            boot_swap_i,
  input  wire logic            lowspeed_osc_i,
  input  wire logic            illegal_access_i,
  input  wire logic            wdt_reset_o,
  input  wire logic            lowspeed_osc_en_o,
  input  wire logic            timer8_tick_o,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  input  wire logic            s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  input  wire logic            s_axi_wready,
  input  wire logic [1:0]      s_axi_bresp,
  input  wire logic            s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic            s_axi_arvalid,
  input  wire logic            s_axi_arready,
  input  wire logic            s_axi_rvalid
);
  // ********
  // Helpers
  // ********
  // Option latch settles well before seven cycles after release
  logic [2:0] rel_cnt;
  wdtoc_opt_t sel;
  logic       both_take;
  assign sel = boot_swap_i ? option_alt_i : option_main_i;
  assign both_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      rel_cnt <= 3'h0;
    else if (rel_cnt != 3'h7)
      rel_cnt <= rel_cnt + 3'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ********
  // Assertions
  // ********
  a_reset_quiet: assert property (disable iff (1'b0) !nrst_i |=>
    !wdt_reset_o && lowspeed_osc_en_o && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active under reset");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_write_answer: assert property (both_take |-> ##3 s_axi_bvalid)
    else $error("write response late");
  a_lock_osc: assert property (rel_cnt == 3'h7 && sel[0] |-> lowspeed_osc_en_o)
    else $error("locked oscillator stopped");
  a_bad_code: assert property (rel_cnt == 3'h7 && sel[4] && both_take && s_axi_wstrb[0]
    && s_axi_awaddr == 8'h00 && s_axi_wdata[7:0] != 8'hac |-> ##[2:3] wdt_reset_o)
    else $error("bad restart code did not trip");
  a_start_off: assert property (rel_cnt == 3'h7 && !sel[4] |-> !wdt_reset_o)
    else $error("trip with watchdog disabled");
  a_illegal_trip: assert property (rel_cnt == 3'h7 && sel[4] && illegal_access_i
    |-> ##[1:2] wdt_reset_o)
    else $error("illegal access did not trip");
  a_tick_follow: assert property ($rose(lowspeed_osc_i) |->
    ##[1:6] (timer8_tick_o || !lowspeed_osc_en_o))
    else $error("timer tick missing");
endmodule

bind wdtoc_top wdtoc_top_checker u_chk
(
  .clk_i, .nrst_i, .option_main_i, .option_alt_i, .boot_swap_i, .lowspeed_osc_i,
  .illegal_access_i, .wdt_reset_o, .lowspeed_osc_en_o, .timer8_tick_o, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);

// file: tb/wdtoc_top_tb.sv
// Self-checking bench for the watchdog option configuration top.
// Assumes the checker binds itself; the oscillator pin is made here.
`timescale 1ns/1ps

module wdtoc_top_tb;
  import wdtoc_pkg::*;
  logic        clk_i, nrst_i, boot_swap_i, lowspeed_osc_i, halt_i, stop_i;
  logic        illegal_access_i, wdt_reset_o, lowspeed_osc_en_o, timer8_tick_o;
  wdtoc_opt_t  option_main_i, option_alt_i, o;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, u;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          errors, num_checks, trips, ticks, t, n, osc_div;

  wdtoc_top dut
  (
    .clk_i, .nrst_i, .option_main_i, .option_alt_i, .boot_swap_i, .lowspeed_osc_i,
    .halt_i, .stop_i, .illegal_access_i, .wdt_reset_o, .lowspeed_osc_en_o, .timer8_tick_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Oscillator stands still while the block has it stopped
  always @(posedge clk_i)
  begin
    osc_div <= (osc_div == 2) ? 0 : osc_div + 1;
    if (osc_div == 2 && lowspeed_osc_en_o !== 1'b0)
      lowspeed_osc_i <= ~lowspeed_osc_i;
    if (wdt_reset_o === 1'b1)
      trips <= trips + 1;
    if (timer8_tick_o === 1'b1)
      ticks <= ticks + 1;
  end

  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic pa, pw;
    @(posedge clk_i);
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (pa || pw)
    begin
      @(posedge clk_i);
      pa = pa && (s_axi_awready !== 1'b1);
      pw = pw && (s_axi_wready !== 1'b1);
      s_axi_awvalid <= pa;
      s_axi_wvalid  <= pw;
    end
    while (s_axi_bvalid !== 1'b1)
      @(posedge clk_i);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    @(posedge clk_i);
    while (s_axi_arready !== 1'b1)
      @(posedge clk_i);
    s_axi_arvalid <= 1'b0;
    @(posedge clk_i);
    while (s_axi_rvalid !== 1'b1)
      @(posedge clk_i);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask

  task automatic rst(input wdtoc_opt_t m, input wdtoc_opt_t al, input logic sw);
    @(posedge clk_i);
    nrst_i        <= 1'b0;
    option_main_i <= m;
    option_alt_i  <= al;
    boot_swap_i   <= sw;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic tchk(input int e);
    repeat (6) @(posedge clk_i);
    chk("trips", e, trips);
  endtask

  task automatic pulse_illegal;
    illegal_access_i <= 1'b1;
    @(posedge clk_i);
    illegal_access_i <= 1'b0;
  endtask

  task automatic conclude;
    $display("Checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ********
  // Sequence
  // ********
  initial
  begin
    {nrst_i, boot_swap_i, lowspeed_osc_i, halt_i, stop_i, illegal_access_i} = 6'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {option_main_i, option_alt_i, s_axi_awaddr, s_axi_araddr} = 32'h0;
    {s_axi_wdata, s_axi_wstrb} = {32'h0, 4'hf};
    {errors, num_checks, trips, ticks, osc_div} = '0;
    for (int w = 0; w < 4; w++)
    begin
      o = {1'b0, w[1:0], 5'h1f};
      rst(o, o, 1'b0);
      axr(8'h80, v, 2'h0);
      chk("option", {24'h0, o}, v);
      axr(8'h0c, v, 2'h0);
      chk("window", w == 3, v[17]);
      chk("active", 1, v[18]);
      t = trips;
      axw(8'h00, 32'h5a, 2'h0);
      tchk(t + 1);
      axr(8'h08, v, 2'h0);
      chk("cause", 32'h10, v);
      axw(8'h08, 32'h0, 2'h0);
      axr(8'h08, v, 2'h0);
      chk("cause_clr", 32'h0, v);
      axw(8'h04, 32'h2, 2'h0);
      repeat (3) @(posedge clk_i);
      chk("osc_locked", 1, lowspeed_osc_en_o);
    end
    rst(8'h5b, 8'h41, 1'b1);
    axr(8'h80, v, 2'h0);
    chk("alt_option", 32'h41, v);
    axr(8'h0c, v, 2'h0);
    chk("mismatch", 1, v[19]);
    chk("inactive", 0, v[18]);
    t = trips;
    pulse_illegal;
    axw(8'h00, 32'h12, 2'h0);
    tchk(t);
    axw(8'h80, 32'h0, 2'h2);
    axr(8'h10, v, 2'h2);
    chk("unmapped", 32'h0, v);
    option_alt_i <= 8'h02;
    axr(8'h80, v, 2'h0);
    chk("held_option", 32'h41, v);
    rst(8'h12, 8'h12, 1'b0);
    t = trips;
    axw(8'h00, 32'hac, 2'h0);
    tchk(t + 1);
    v = 32'h0;
    while (v[16:0] < 17'd1536)
      axr(8'h0c, v, 2'h0);
    chk("open", 1, v[17]);
    t = trips;
    axw(8'h00, 32'hac, 2'h0);
    tchk(t);
    axr(8'h0c, v, 2'h0);
    chk("cleared", 1, v[16:0] < 17'd16);
    axw(8'h04, 32'h2, 2'h0);
    repeat (3) @(posedge clk_i);
    chk("osc_stop", 0, lowspeed_osc_en_o);
    axw(8'h04, 32'h0, 2'h0);
    repeat (3) @(posedge clk_i);
    chk("osc_run", 1, lowspeed_osc_en_o);
    for (int i = 0; i < 2; i++)
    begin
      halt_i <= (i == 0);
      stop_i <= (i == 1);
      repeat (4) @(posedge clk_i);
      axr(8'h0c, v, 2'h0);
      n = ticks;
      repeat (60) @(posedge clk_i);
      axr(8'h0c, u, 2'h0);
      chk("held_count", v[16:0], u[16:0]);
      chk("timer_ticks", 1, ticks > n);
    end
    halt_i <= 1'b0;
    stop_i <= 1'b0;
    t = trips;
    pulse_illegal;
    tchk(t + 1);
    n = 0;
    // 2048 ticks of six clocks each, counted from just after the trip
    while (trips == t + 1)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("period", 1, n > 12250 && n < 12300);
    conclude;
  end

  // Tests need about 25000 cycles
  initial
  begin
    repeat (60000) @(posedge clk_i);
    errors++;
    conclude;
  end
endmodule
